// ===== dv/clafl_host_model.sv
// Purpose: host side that watches the alarm interrupt line
// Assumes: interrupt is an active high pulse on CLK
// Notes:   counts rising edges and high cycles so width errors show up
`timescale 1ns/10ps
module clafl_host_model (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CHARGE_STATE_IRQ,
    output logic [7:0]      irq_pulses,
    output logic [7:0]      irq_high
);
    logic irq_prev;

    ////////////////////////////////////////////////////////////////////////////
    // edge counter; a stuck-high line gives more high cycles than pulses
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_prev   <= 1'b0;
            irq_pulses <= 8'h00;
            irq_high   <= 8'h00;
        end else begin
            irq_prev <= CHARGE_STATE_IRQ;
            if (CHARGE_STATE_IRQ) irq_high <= irq_high + 8'h01;
            if (CHARGE_STATE_IRQ && !irq_prev) irq_pulses <= irq_pulses + 8'h01;
        end
    end
endmodule : clafl_host_model

// ===== dv/clafl_tb_top.sv
// Purpose: self-checking bench for the alarm flag block
// Assumes: classic wishbone, ack one cycle after the taking edge
// Notes:   charge is sent in whole mAh steps so residue never blurs results
`timescale 1ns/10ps
module clafl_tb_top;
    import clafl_pkg::*;
    logic clk, rst, cyc, stb, we, chg_valid, volt_valid, low_pin, irq, ack;
    logic [7:0]         adr;
    logic [3:0]         sel;
    logic [31:0]        wdat, rdat, dat_o;
    logic signed [15:0] chg_uah;
    logic [15:0]        volt_mv;
    logic [7:0]         irq_pulses, irq_high;
    int                 miscompares, comparisons;

    clafl_top i_clafl_top (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .CHARGE_VALID(chg_valid), .CHARGE_UAH(chg_uah), .VOLT_VALID(volt_valid), .VOLT_MV(volt_mv),
        .CAPACITY_LOW_PIN(low_pin), .CHARGE_STATE_IRQ(irq));
    clafl_host_model i_clafl_host_model (.CLK(clk), .RST(rst), .CHARGE_STATE_IRQ(irq),
        .irq_pulses(irq_pulses), .irq_high(irq_high));

    ////////////////////////////////////////////////////////////////////////////
    // verdict, also reached from a bus timeout
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check

    // one classic cycle; bounded wait so a missing ack cannot hang the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1) begin
            $display("CHECK FAILED bus ack expected 1 seen timeout");
            miscompares++;
            give_verdict();
        end
    endtask : wb

    task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hf, 32'h0000_0000);
        check(name, rdat, exp);
    endtask : rd_check

    // flag word and the mirrored pin together
    task automatic flags_check(input logic [2:0] e);
        rd_check("flags", CLAFL_OFF_FLAGS, {29'h0, e});
        check("pin", {31'h0, low_pin}, {31'h0, e[CLAFL_FLAG_CAPLOW]});
    endtask : flags_check

    // two back to back samples making exactly one mAh
    task automatic send_mah(input logic signed [15:0] a, input logic signed [15:0] b);
        @(posedge clk);
        chg_valid <= 1'b1;
        chg_uah   <= a;
        @(posedge clk);
        chg_uah   <= b;
        @(posedge clk);
        chg_valid <= 1'b0;
        chg_uah   <= ~b;
        repeat (2) @(posedge clk);
    endtask : send_mah

    ////////////////////////////////////////////////////////////////////////////
    // register defaults, read-only and unmapped places
    task automatic scen_reset;
        rd_check("cap_limit", CLAFL_OFF_CAP_LIMIT, clafl_word(CLAFL_CAP_LIMIT_RST));
        rd_check("set_limit", CLAFL_OFF_SET_LIMIT, clafl_word(CLAFL_SET_LIMIT_RST));
        rd_check("rel_limit", CLAFL_OFF_REL_LIMIT, clafl_word(CLAFL_REL_LIMIT_RST));
        // low byte lane alone, then the default restored
        wb(1'b1, CLAFL_OFF_SET_LIMIT, 4'h1, 32'h0000_aa55);
        rd_check("set_limit_lane0", CLAFL_OFF_SET_LIMIT, 32'h0000_0c55);
        wb(1'b1, CLAFL_OFF_SET_LIMIT, 4'h3, clafl_word(CLAFL_SET_LIMIT_RST));
        rd_check("remain", CLAFL_OFF_REMAIN, 32'h0000_0000);
        wb(1'b1, 8'h18, 4'hf, 32'h0000_ffff);
        rd_check("unmapped", 8'h18, CLAFL_READ_UNMAPPED);
        wb(1'b1, CLAFL_OFF_FLAGS, 4'hf, 32'h0000_ffff);
        flags_check(3'b001);
    endtask : scen_reset

    // hysteresis around a rewritten limit of 200 mAh
    task automatic scen_capacity;
        wb(1'b1, CLAFL_OFF_CAP_LIMIT, 4'h3, 32'h0000_00c8);
        rd_check("cap_limit_wr", CLAFL_OFF_CAP_LIMIT, 32'h0000_00c8);
        wb(1'b1, CLAFL_OFF_REMAIN, 4'h1, 32'h0000_00c9);
        rd_check("remain_partial", CLAFL_OFF_REMAIN, 32'h0000_0000);
        wb(1'b1, CLAFL_OFF_REMAIN, 4'h3, 32'h0000_00c9);
        flags_check(3'b000);
        send_mah(-16'sd999, -16'sd1);
        rd_check("remain_dn", CLAFL_OFF_REMAIN, 32'h0000_00c8);
        flags_check(3'b000);
        send_mah(-16'sd999, -16'sd1);
        flags_check(3'b001);
        send_mah(16'sd999, 16'sd1);
        rd_check("remain_up", CLAFL_OFF_REMAIN, 32'h0000_00c8);
        flags_check(3'b001);
        send_mah(16'sd999, 16'sd1);
        flags_check(3'b000);
        // clamp: an oversized sample moves at most 999 uAh
        send_mah(16'sd1, 16'sd2000);
        rd_check("remain_clamp_up", CLAFL_OFF_REMAIN, 32'h0000_00ca);
        send_mah(-16'sd2000, -16'sd1);
        rd_check("remain_clamp_dn", CLAFL_OFF_REMAIN, 32'h0000_00c9);
        // empty cell saturates at zero instead of wrapping
        wb(1'b1, CLAFL_OFF_REMAIN, 4'h3, 32'h0000_0000);
        send_mah(-16'sd999, -16'sd1);
        rd_check("remain_floor", CLAFL_OFF_REMAIN, 32'h0000_0000);
        wb(1'b1, CLAFL_OFF_REMAIN, 4'h3, 32'h0000_00c9);
    endtask : scen_capacity

    // voltage steps at and across both shutdown limits
    task automatic scen_voltage;
        logic [15:0] vt [6];
        logic [5:0]  sd;
        logic [7:0]  np [6];
        vt = '{16'd3100, 16'd3099, 16'd3000, 16'd3400, 16'd3401, 16'd3500};
        sd = 6'b001110;
        np = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            volt_valid <= 1'b1;
            volt_mv    <= vt[i];
            @(posedge clk);
            volt_valid <= 1'b0;
            volt_mv    <= ~vt[i];
            repeat (3) @(posedge clk);
            rd_check("voltage", CLAFL_OFF_VOLTAGE, clafl_word(vt[i]));
            flags_check({1'b1, sd[i], 1'b0});
            check("irq_pulses", {24'h0, irq_pulses}, {24'h0, np[i]});
            check("irq_high", {24'h0, irq_high}, {24'h0, np[i]});
        end
    endtask : scen_voltage

    ////////////////////////////////////////////////////////////////////////////
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {rst, cyc, stb, we, chg_valid, volt_valid} = 6'b100000;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        chg_uah = 16'sd0;
        volt_mv = 16'h0;
        miscompares = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        scen_reset();
        scen_capacity();
        scen_voltage();
        give_verdict();
    end
endmodule : clafl_tb_top

// ===== verilog/clafl_charge_integ.sv
// Purpose: integrates signed charge increments into remaining charge in mAh
// Assumes: each increment is in uAh, magnitude clamped to below one mAh
// Notes:   sub-mAh residue is kept so small currents are never lost
`timescale 1ns/10ps
module clafl_charge_integ
    import clafl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   sample_valid,
    input  wire logic signed [15:0]     sample_uah,
    input  wire logic                   load,
    input  wire logic [15:0]            load_value,
    output logic [15:0]                 remain_mah
);

    localparam logic signed [17:0] UAH_MAX  = 18'(CLAFL_UAH_PER_MAH - 1);
    localparam logic signed [17:0] UAH_UNIT = 18'(CLAFL_UAH_PER_MAH);

    logic        [9:0]  frac;
    logic        [9:0]  next_frac;
    logic        [15:0] next_remain;
    logic signed [17:0] delta;
    logic signed [17:0] sum;

    // accumulate charge in and out of the cell, carry whole mAh
    always_comb begin
        delta       = 18'(sample_uah);
        sum         = 18'sd0;
        next_frac   = frac;
        next_remain = remain_mah;
        if (delta > UAH_MAX) begin
            delta = UAH_MAX;
        end else if (delta < -UAH_MAX) begin
            delta = -UAH_MAX;
        end
        if (load) begin
            next_frac   = 10'h000;
            next_remain = load_value;
        end else if (sample_valid) begin
            sum = $signed({8'h00, frac}) + delta;
            if (sum >= UAH_UNIT) begin
                if (remain_mah != 16'hffff) begin
                    next_remain = remain_mah + 16'h0001;
                    next_frac   = 10'(sum - UAH_UNIT);
                end else begin
                    next_frac   = 10'(UAH_MAX); // saturate, never wrap to empty
                end
            end else if (sum < 18'sd0) begin
                if (remain_mah != 16'h0000) begin
                    next_remain = remain_mah - 16'h0001;
                    next_frac   = 10'(sum + UAH_UNIT);
                end else begin
                    next_frac   = 10'h000;
                end
            end else begin
                next_frac = 10'(sum);
            end
        end
    end

    // register integrator state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frac       <= 10'h000;
            remain_mah <= CLAFL_REMAIN_RST;
        end else begin
            frac       <= next_frac;
            remain_mah <= next_remain;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_integ_charge: assert property (sample_valid && !load && sample_uah >= 16'sd1000
        && frac != 10'h000 && remain_mah != 16'hffff |=> remain_mah == $past(remain_mah) + 16'h0001)
        else $error("charging did not raise remaining charge");
    a_integ_drain: assert property (sample_valid && !load && sample_uah <= -16'sd1000
        && frac != 10'h3e7 && remain_mah != 16'h0000 |=> remain_mah == $past(remain_mah) - 16'h0001)
        else $error("discharging did not lower remaining charge");
    a_integ_idle: assert property (!sample_valid && !load |=> $stable(remain_mah))
        else $error("remaining charge moved without a sample");

endmodule : clafl_charge_integ

// ===== verilog/clafl_pkg.sv
// Purpose: shared constants for the charge level alarm flag block
// Assumes: 32-bit classic Wishbone register bus, 16-bit measurement words
// Notes:   offsets are byte addresses, one aligned word per register
package clafl_pkg;

    // measurement word width
    localparam int          CLAFL_VAL_W          = 16;

    // register byte offsets
    localparam logic [7:0]  CLAFL_OFF_FLAGS      = 8'h00;
    localparam logic [7:0]  CLAFL_OFF_REMAIN     = 8'h04;
    localparam logic [7:0]  CLAFL_OFF_VOLTAGE    = 8'h08;
    localparam logic [7:0]  CLAFL_OFF_CAP_LIMIT  = 8'h0c;
    localparam logic [7:0]  CLAFL_OFF_SET_LIMIT  = 8'h10;
    localparam logic [7:0]  CLAFL_OFF_REL_LIMIT  = 8'h14;

    // flag word field positions
    localparam int          CLAFL_FLAG_CAPLOW    = 0;
    localparam int          CLAFL_FLAG_SHUTDOWN  = 1;
    localparam int          CLAFL_FLAG_VSEEN     = 2;

    // reset values and the unmapped read value
    localparam logic [15:0] CLAFL_CAP_LIMIT_RST  = 16'h0096;
    localparam logic [15:0] CLAFL_SET_LIMIT_RST  = 16'h0c1c;
    localparam logic [15:0] CLAFL_REL_LIMIT_RST  = 16'h0d48;
    localparam logic [15:0] CLAFL_REMAIN_RST     = 16'h0000;
    localparam logic [31:0] CLAFL_READ_UNMAPPED  = 32'h0000_0000;

    // charge integration: micro-amp-hours per milli-amp-hour
    localparam int          CLAFL_UAH_PER_MAH    = 1000;

    // zero-extend a 16-bit value into a bus word
    function automatic logic [31:0] clafl_word(input logic [15:0] v);
        clafl_word = {16'h0000, v};
    endfunction : clafl_word

endpackage : clafl_pkg

// ===== verilog/clafl_top.sv
// Purpose: low-capacity and shutdown-voltage alarm flags of a fuel gauge
// Assumes: charge and voltage samples come from logic on CLK with a valid strobe
// Notes:   flags only track voltage once the first voltage sample has arrived
//
// Behaviour
// - remaining charge follows integrated sense charge in both directions
// - both alarm flags are readable bits of the flag word
// - low-capacity flag sets when remaining charge is below its limit
// - low-capacity flag clears only once remaining charge rises above limit
// - low-capacity pin always mirrors the low-capacity flag
// - shutdown flag sets when cell voltage is below the set limit
// - shutdown flag clears only if set and voltage above release limit
// - interrupt signals on every change of the shutdown flag
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module clafl_top
    import clafl_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [7:0]             WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic [31:0]                 WB_DAT_O,
    output logic                        WB_ACK_O,
    input  wire logic                   CHARGE_VALID,
    input  wire logic signed [15:0]     CHARGE_UAH,
    input  wire logic                   VOLT_VALID,
    input  wire logic [15:0]            VOLT_MV,
    output logic                        CAPACITY_LOW_PIN,
    output logic                        CHARGE_STATE_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [15:0] remaining_charge_value;
    logic [15:0] cell_voltage_value;
    logic [15:0] next_voltage;
    logic        volt_seen;
    logic        next_volt_seen;
    logic [15:0] capacity_low_limit;
    logic [15:0] shutdown_set_limit;
    logic [15:0] shutdown_release_limit;
    logic [15:0] next_cap_limit;
    logic [15:0] next_set_limit;
    logic [15:0] next_rel_limit;
    logic        capacity_low_flag;
    logic        shutdown_voltage_flag;
    logic        next_cap_low;
    logic        next_shutdown;
    logic        next_irq;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        wr_req;
    logic        remain_load;
    logic [15:0] wr_half;

    ////////////////////////////////////////////////////////////////////////
    // charge integration

    clafl_charge_integ u_integ (
        .clk          (CLK),
        .rst          (RST),
        .sample_valid (CHARGE_VALID),
        .sample_uah   (CHARGE_UAH),
        .load         (remain_load),
        .load_value   (wr_half),
        .remain_mah   (remaining_charge_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack dropped after one cycle

    // writes land at the edge where the master sees ack, so a held request writes once
    assign wr_req      = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
    assign remain_load = wr_req && WB_ADR_I == CLAFL_OFF_REMAIN && WB_SEL_I[1:0] == 2'b11;

    // merge byte lanes of the low half-word
    always_comb begin
        wr_half = 16'h0000;
        next_ack = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        next_dat = WB_DAT_O;
        case (WB_ADR_I)
            CLAFL_OFF_CAP_LIMIT: wr_half = capacity_low_limit;
            CLAFL_OFF_SET_LIMIT: wr_half = shutdown_set_limit;
            CLAFL_OFF_REL_LIMIT: wr_half = shutdown_release_limit;
            default:             wr_half = remaining_charge_value;
        endcase
        if (WB_SEL_I[0]) begin
            wr_half[7:0] = WB_DAT_I[7:0];
        end
        if (WB_SEL_I[1]) begin
            wr_half[15:8] = WB_DAT_I[15:8];
        end
        if (next_ack && !WB_WE_I) begin
            case (WB_ADR_I)
                CLAFL_OFF_FLAGS:     next_dat = {29'h0, volt_seen, next_shutdown, next_cap_low};
                CLAFL_OFF_REMAIN:    next_dat = clafl_word(remaining_charge_value);
                CLAFL_OFF_VOLTAGE:   next_dat = clafl_word(cell_voltage_value);
                CLAFL_OFF_CAP_LIMIT: next_dat = clafl_word(capacity_low_limit);
                CLAFL_OFF_SET_LIMIT: next_dat = clafl_word(shutdown_set_limit);
                CLAFL_OFF_REL_LIMIT: next_dat = clafl_word(shutdown_release_limit);
                default:             next_dat = CLAFL_READ_UNMAPPED;
            endcase
        end
    end

    // register bus answer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= next_ack;
            WB_DAT_O <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // threshold registers and voltage capture

    // limits are software-written; voltage follows the measurement strobe
    always_comb begin
        next_cap_limit = capacity_low_limit;
        next_set_limit = shutdown_set_limit;
        next_rel_limit = shutdown_release_limit;
        next_voltage   = cell_voltage_value;
        next_volt_seen = volt_seen;
        if (wr_req && WB_ADR_I == CLAFL_OFF_CAP_LIMIT) begin
            next_cap_limit = wr_half;
        end
        if (wr_req && WB_ADR_I == CLAFL_OFF_SET_LIMIT) begin
            next_set_limit = wr_half;
        end
        if (wr_req && WB_ADR_I == CLAFL_OFF_REL_LIMIT) begin
            next_rel_limit = wr_half;
        end
        if (VOLT_VALID) begin
            next_voltage   = VOLT_MV;
            next_volt_seen = 1'b1;
        end
    end

    // register limits and voltage
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            capacity_low_limit     <= CLAFL_CAP_LIMIT_RST;
            shutdown_set_limit     <= CLAFL_SET_LIMIT_RST;
            shutdown_release_limit <= CLAFL_REL_LIMIT_RST;
            cell_voltage_value     <= 16'h0000;
            volt_seen              <= 1'b0;
        end else begin
            capacity_low_limit     <= next_cap_limit;
            shutdown_set_limit     <= next_set_limit;
            shutdown_release_limit <= next_rel_limit;
            cell_voltage_value     <= next_voltage;
            volt_seen              <= next_volt_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm flags, pin and interrupt

    // hysteresis: equal to the limit holds the present state
    always_comb begin
        next_cap_low  = capacity_low_flag;
        next_shutdown = shutdown_voltage_flag;
        if (remaining_charge_value < capacity_low_limit) begin
            next_cap_low = 1'b1;
        end else if (remaining_charge_value > capacity_low_limit) begin
            next_cap_low = 1'b0;
        end
        // set wins if limits are programmed inconsistently
        if (volt_seen && cell_voltage_value < shutdown_set_limit) begin
            next_shutdown = 1'b1;
        end else if (volt_seen && shutdown_voltage_flag && cell_voltage_value > shutdown_release_limit) begin
            next_shutdown = 1'b0;
        end
        next_irq = next_shutdown != shutdown_voltage_flag;
    end

    // pin is loaded from the same next value as the flag, so never lags it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            capacity_low_flag     <= 1'b0;
            shutdown_voltage_flag <= 1'b0;
            CAPACITY_LOW_PIN      <= 1'b0;
            CHARGE_STATE_IRQ      <= 1'b0;
        end else begin
            capacity_low_flag     <= next_cap_low;
            shutdown_voltage_flag <= next_shutdown;
            CAPACITY_LOW_PIN      <= next_cap_low;
            CHARGE_STATE_IRQ      <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_flag_read;
        WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O && WB_ADR_I == CLAFL_OFF_FLAGS;
    endsequence

    sequence s_flag_answer;
        ##1 WB_ACK_O && WB_DAT_O[CLAFL_FLAG_CAPLOW] == capacity_low_flag
            && WB_DAT_O[CLAFL_FLAG_SHUTDOWN] == shutdown_voltage_flag;
    endsequence

    a_flag_word_read: assert property (s_flag_read |-> s_flag_answer)
        else $error("flag word read does not show the alarm flags");
    a_caplow_set: assert property (remaining_charge_value < capacity_low_limit |=> capacity_low_flag)
        else $error("low-capacity flag not set below limit");
    a_caplow_clear: assert property ($fell(capacity_low_flag)
        |-> $past(remaining_charge_value) > $past(capacity_low_limit))
        else $error("low-capacity flag cleared without charge above limit");
    a_caplow_pin: assert property (CAPACITY_LOW_PIN == capacity_low_flag)
        else $error("low-capacity pin differs from flag");
    a_shut_set: assert property (volt_seen && cell_voltage_value < shutdown_set_limit
        |=> shutdown_voltage_flag)
        else $error("shutdown flag not set below set limit");
    a_shut_clear: assert property ($fell(shutdown_voltage_flag)
        |-> $past(cell_voltage_value) > $past(shutdown_release_limit) && $past(volt_seen))
        else $error("shutdown flag cleared without voltage above release limit");
    a_irq_change: assert property ($changed(shutdown_voltage_flag) |-> CHARGE_STATE_IRQ)
        else $error("shutdown flag change gave no interrupt");
    a_irq_single: assert property (CHARGE_STATE_IRQ
        |-> $changed(shutdown_voltage_flag) ##1 !CHARGE_STATE_IRQ || $changed(shutdown_voltage_flag))
        else $error("interrupt not a single pulse per transition");

endmodule : clafl_top
